/* pid_run_mode_sequencer_tb.sv */
// Purpose: Self-checking bench for pidsq_top.
// Assumes: Timer tick shortened to 10 cycles.
// Notes:   PID arithmetic output is driven by the bench.
`timescale 1ns/1ns
`default_nettype none
`include "pidsq_defs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
`define SET(s, v) begin @(posedge clk_sys_i); s <= v; end
`define WAITFOR(c, n) begin int k; k = 0; \
    while (!(c) && k < n) begin @(negedge clk_sys_i); k++; end end
module pid_run_mode_sequencer_tb;
    logic        clk_sys_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic [31:0] rd_v;
    logic        pready_o, pslverr_o, err_v, irq_o;
    logic        running_o, startup_trip_o, sleeping_o, bypass_active_o;
    logic [10:0] mfi = 11'h000;
    logic [15:0] ref_pct = 16'h0000;
    logic [15:0] pid_pct = 16'h0000;
    logic [15:0] fb_lvl = 16'h0000;
    logic [15:0] fb_pct, freq_cmd_o;
    int          err_total = 0;
    int          total_checks = 0;
    logic [15:0] nowake [3] = '{16'h2000, 16'h0800, 16'h2800};
    logic [15:0] wake [3] = '{16'h0800, 16'h2000, 16'h1000};
    logic [31:0] c_ctl [4] = '{32'h1, 32'h1, 32'h1, 32'h5};
    logic [31:0] c_lim [4] = '{32'h40000000, 32'h40001000, 32'h4000c000, 32'h4000c000};
    logic [15:0] c_pid [4] = '{16'h6000, 16'h0800, 16'he000, 16'he000};
    logic [15:0] c_exp [4] = '{16'h1770, 16'h05dc, 16'h0000, 16'hf448};

    always #4 clk_sys_i = ~clk_sys_i;

    pidsq_top #(.TICK_CYCLES(10)) dut_u (
        .clk_sys_i              (clk_sys_i),
        .resetn_i               (resetn_i),
        .psel_i                 (psel_i),
        .penable_i              (penable_i),
        .pwrite_i               (pwrite_i),
        .paddr_i                (paddr_i),
        .pwdata_i               (pwdata_i),
        .prdata_o               (prdata_o),
        .pready_o               (pready_o),
        .pslverr_o              (pslverr_o),
        .multi_function_inputs_i(mfi),
        .reference_pct_i        (ref_pct),
        .feedback_pct_i         (fb_pct),
        .pid_output_pct_i       (pid_pct),
        .freq_cmd_o             (freq_cmd_o),
        .running_o              (running_o),
        .startup_trip_o         (startup_trip_o),
        .sleeping_o             (sleeping_o),
        .bypass_active_o        (bypass_active_o),
        .irq_o                  (irq_o)
    );

    pidsq_plant plant_u (
        .clk_sys_i     (clk_sys_i),
        .level_i       (fb_lvl),
        .feedback_pct_o(fb_pct)
    );

    // Answer taken at the edge that samples ready high; only the watchdog ends a wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
        end while (pready_o !== 1'b1);
        rd_v = prdata_o;
        err_v = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic final_report;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_total++;
        final_report;
    end

    initial begin
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        rd(`PIDSQ_OFS_MAXF);
        `CHK(rd_v, 32'h00001770)
        rd(`PIDSQ_OFS_LIMIT);
        `CHK(rd_v, 32'h40000000)
        rd(8'h40);
        `CHK(err_v, 1'b1)
        `CHK(rd_v, 32'h0)
        wr(`PIDSQ_OFS_IMASK, 32'hf);
        wr(`PIDSQ_OFS_SU_FREQ, 32'h0100);
        wr(`PIDSQ_OFS_SU_EXIT, 32'h1000);
        wr(`PIDSQ_OFS_SU_DLY, 32'h3);
        wr(`PIDSQ_OFS_CTRL, 32'h3);
        cyc(3);
        `CHK(freq_cmd_o, 16'h0100)
        `CHK(running_o, 1'b1)
        `WAITFOR(startup_trip_o === 1'b1, 100)
        `CHK(startup_trip_o, 1'b1)
        `CHK(freq_cmd_o, 16'h0000)
        `CHK(irq_o, 1'b1)
        wr(`PIDSQ_OFS_ISTAT, 32'h1);
        rd(`PIDSQ_OFS_ISTAT);
        `CHK(rd_v, 32'h0)
        `CHK(irq_o, 1'b0)
        wr(`PIDSQ_OFS_CTRL, 32'h0);
        `SET(fb_lvl, 16'h2000)
        `SET(pid_pct, 16'h2000)
        wr(`PIDSQ_OFS_SL_DLY, 32'h7fff);
        wr(`PIDSQ_OFS_CTRL, 32'h3);
        cyc(4);
        `CHK(freq_cmd_o, 16'h0bb8)
        rd(`PIDSQ_OFS_FOUT);
        `CHK(rd_v, 32'h0bb8)
        for (int i = 0; i < 4; i++) begin
            wr(`PIDSQ_OFS_CTRL, c_ctl[i]);
            wr(`PIDSQ_OFS_LIMIT, c_lim[i]);
            `SET(pid_pct, c_pid[i])
            cyc(3);
            `CHK(freq_cmd_o, c_exp[i])
        end
        // Freq must sit above the sleep level before the short delay is armed
        `SET(pid_pct, 16'h2000)
        wr(`PIDSQ_OFS_CTRL, 32'h1);
        wr(`PIDSQ_OFS_SL_FREQ, 32'h0200);
        wr(`PIDSQ_OFS_WAKE_LEV, 32'h1000);
        `SET(ref_pct, 16'h3000)
        wr(`PIDSQ_OFS_SL_DLY, 32'h5);
        `SET(pid_pct, 16'h0000)
        cyc(30);
        `SET(pid_pct, 16'h2000)
        cyc(3);
        `SET(pid_pct, 16'h0000)
        cyc(30);
        `CHK(sleeping_o, 1'b0)
        `WAITFOR(sleeping_o === 1'b1, 100)
        `CHK(sleeping_o, 1'b1)
        for (int m = 0; m < 3; m++) begin
            `SET(fb_lvl, nowake[m])
            wr(`PIDSQ_OFS_CTRL, 32'(1 + (m << 4)));
            `WAITFOR(sleeping_o === 1'b1, 150)
            cyc(10);
            `CHK(sleeping_o, 1'b1)
            `SET(fb_lvl, wake[m])
            `WAITFOR(sleeping_o === 1'b0, 10)
            `CHK(running_o, 1'b1)
        end
        `SET(pid_pct, 16'h2000)
        rd(`PIDSQ_OFS_ISTAT);
        `CHK(rd_v, 32'h6)
        `CHK(irq_o, 1'b1)
        wr(`PIDSQ_OFS_ISTAT, 32'h6);
        cyc(2);
        `CHK(irq_o, 1'b0)
        wr(`PIDSQ_OFS_IMASK, 32'h0);
        wr(`PIDSQ_OFS_BYP, 32'h317);
        `SET(mfi, 11'h008)
        cyc(10);
        `CHK(bypass_active_o, 1'b0)
        wr(`PIDSQ_OFS_BYP, 32'h316);
        `WAITFOR(bypass_active_o === 1'b1, 10)
        `CHK(bypass_active_o, 1'b1)
        `CHK(freq_cmd_o, 16'h1194)
        `CHK(irq_o, 1'b0)
        rd(`PIDSQ_OFS_ISTAT);
        `CHK(rd_v, 32'h8)
        rd(`PIDSQ_OFS_STAT);
        `CHK(rd_v, 32'hc)
        `SET(mfi, 11'h000)
        `WAITFOR(bypass_active_o === 1'b0, 10)
        cyc(2);
        `CHK(running_o, 1'b1)
        `CHK(freq_cmd_o, 16'h0bb8)
        final_report;
    end
endmodule
`default_nettype wire

/* pidsq_checker_asserts.sv */
// Purpose: Port-level checks for pidsq_top.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Register contents are not visible from the ports.
`timescale 1ns/1ns
`default_nettype none
module pidsq_checker #(
    parameter TICK_CYCLES = 10
) (
    input wire logic        clk_sys_i,
    input wire logic        resetn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [15:0] freq_cmd_o,
    input wire logic        running_o,
    input wire logic        startup_trip_o,
    input wire logic        sleeping_o,
    input wire logic        bypass_active_o
);
    default clocking dc @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
        else $error("ready missing after setup");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    trip_stops_a: assert property (
        startup_trip_o |-> !running_o && freq_cmd_o == 16'h0000)
        else $error("output not stopped in trip");
    trip_from_start_a: assert property (
        $rose(startup_trip_o) |-> $past(running_o) && !$past(bypass_active_o))
        else $error("trip not from startup");
    sleep_stops_a: assert property (
        sleeping_o |-> !running_o && freq_cmd_o == 16'h0000)
        else $error("output not stopped in sleep");
    sleep_from_pid_a: assert property (
        $rose(sleeping_o) |-> $past(running_o) && !$past(bypass_active_o))
        else $error("sleep not from closed loop");
    // Leaving sleep without running is only legal in the cycle after any APB transfer is answered (pready_o high)
    wake_resumes_a: assert property ($fell(sleeping_o) |-> running_o || $past(pready_o))
        else $error("wake did not resume running");
    bypass_runs_a: assert property (
        bypass_active_o |-> running_o && !sleeping_o && !startup_trip_o)
        else $error("bypass without running");
endmodule

bind pidsq_top pidsq_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .clk_sys_i      (clk_sys_i),
    .resetn_i       (resetn_i),
    .psel_i         (psel_i),
    .penable_i      (penable_i),
    .pready_o       (pready_o),
    .pslverr_o      (pslverr_o),
    .freq_cmd_o     (freq_cmd_o),
    .running_o      (running_o),
    .startup_trip_o (startup_trip_o),
    .sleeping_o     (sleeping_o),
    .bypass_active_o(bypass_active_o)
);
`default_nettype wire

/* pidsq_defs.vh */
// Purpose: Constants for the PID run-mode sequencer.
// Assumes: 125 MHz system clock; percent values use 0x4000 as 100 %.
// Notes:   Frequencies are signed 16-bit in 0.01 Hz steps.
`ifndef PIDSQ_DEFS_VH
`define PIDSQ_DEFS_VH

`define PIDSQ_CLK_NS          8
`define PIDSQ_TICK_NS         1000000
`define PIDSQ_TICK_CYCLES     (`PIDSQ_TICK_NS / `PIDSQ_CLK_NS)

`define PIDSQ_OFS_CTRL        8'h00
`define PIDSQ_OFS_MAXF        8'h04
`define PIDSQ_OFS_LIMIT       8'h08
`define PIDSQ_OFS_SU_FREQ     8'h0c
`define PIDSQ_OFS_SU_EXIT     8'h10
`define PIDSQ_OFS_SU_DLY      8'h14
`define PIDSQ_OFS_SL_DLY      8'h18
`define PIDSQ_OFS_SL_FREQ     8'h1c
`define PIDSQ_OFS_WAKE_LEV    8'h20
`define PIDSQ_OFS_BYP         8'h24
`define PIDSQ_OFS_STAT        8'h28
`define PIDSQ_OFS_ISTAT       8'h2c
`define PIDSQ_OFS_IMASK       8'h30
`define PIDSQ_OFS_FOUT        8'h34

`define PIDSQ_CTRL_RUN        0
`define PIDSQ_CTRL_SU_EN      1
`define PIDSQ_CTRL_REV        2
`define PIDSQ_CTRL_WMODE      4
`define PIDSQ_BYP_CODE        0
`define PIDSQ_BYP_TERM        8

`define PIDSQ_IRQ_TRIP        0
`define PIDSQ_IRQ_SLEEP       1
`define PIDSQ_IRQ_WAKE        2
`define PIDSQ_IRQ_BYP         3

`define PIDSQ_RST_CTRL        8'h00
`define PIDSQ_RST_MAXF        16'h1770
`define PIDSQ_RST_LIM_HI      16'h4000
`define PIDSQ_RST_LIM_LO      16'h0000
`define PIDSQ_RST_WORD        16'h0000
`define PIDSQ_RST_BYP         12'h000

`define PIDSQ_FUNC_OPENLOOP   8'h16
`define PIDSQ_FS_SHIFT        14
`define PIDSQ_N_TERM          11

`endif

/* pidsq_hold_timer.v */
// Purpose: Counts how long a condition has held without a break.
// Assumes: tick_i is a one-cycle pulse per time unit.
// Notes:   Any break in the condition restarts the count at zero.
`timescale 1ns/1ns
`default_nettype none

module pidsq_hold_timer (
    input  wire        clk_sys_i,
    input  wire        resetn_i,
    input  wire        tick_i,
    input  wire        hold_i,
    input  wire [15:0] limit_i,
    output reg         expired_o
);
    reg [15:0] count_reg;

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_reg <= 16'h0000;
            expired_o <= 1'b0;
        end else if (!hold_i) begin
            count_reg <= 16'h0000;
            expired_o <= 1'b0;
        end else begin
            if (tick_i && count_reg != 16'hffff)
                count_reg <= count_reg + 16'h0001;
            expired_o <= (count_reg >= limit_i);
        end
    end
endmodule

`default_nettype wire

/* pidsq_plant.sv */
// Purpose: Process feedback sensor beside the drive.
// Assumes: Bench sets the process level directly.
// Notes:   Feedback lags the process by one cycle.
`timescale 1ns/1ns
`default_nettype none
module pidsq_plant (
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] level_i,
    output var  logic [15:0] feedback_pct_o
);
    // Sensor conversion delay, so the drive never sees a same-edge step
    always @(posedge clk_sys_i) begin
        feedback_pct_o <= level_i;
    end
endmodule
`default_nettype wire

/* pidsq_top.v */
// Purpose: Run-mode sequencing around a PID process controller.
// Assumes: Percent and PID inputs come from logic on clk_sys_i.
// Notes:   Delay registers count 1 ms ticks; frequency is 0.01 Hz.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "pidsq_defs.vh"

// Summary of operation
// - PID output is signed, clamped between upper and lower output limits.
// - 100 percent maps to the configured maximum output frequency.
// - In open-loop operation the reference percent is scaled to the maximum frequency.
// - Startup phase holds target frequency until feedback passes exit level.
// - Feedback at or below exit level for the startup delay trips and stops output.
// - Frequency below sleep frequency for the sleep delay enters sleep.
// - Wake mode 0 resumes when feedback falls below wake level.
// - Wake mode 1 resumes when feedback rises above wake level.
// - Wake mode 2 resumes when reference minus feedback exceeds wake level.
// - Terminal with function 22 forces general operation while asserted, except in trip or with run off.
// - Without reverse enable the PID frequency never goes below zero.
module pidsq_top #(
    parameter TICK_CYCLES = `PIDSQ_TICK_CYCLES
) (
    input  wire        clk_sys_i,
    input  wire        resetn_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire [10:0] multi_function_inputs_i,
    input  wire [15:0] reference_pct_i,
    input  wire [15:0] feedback_pct_i,
    input  wire [15:0] pid_output_pct_i,
    output reg  [15:0] freq_cmd_o,
    output reg         running_o,
    output reg         startup_trip_o,
    output reg         sleeping_o,
    output reg         bypass_active_o,
    output reg         irq_o
);
    localparam [2:0] ST_IDLE    = 3'h0;
    localparam [2:0] ST_STARTUP = 3'h1;
    localparam [2:0] ST_PID     = 3'h2;
    localparam [2:0] ST_SLEEP   = 3'h3;
    localparam [2:0] ST_BYPASS  = 3'h4;
    localparam [2:0] ST_TRIP    = 3'h5;

    // Percent times fmax, full scale 0x4000; overrange inputs wrap
    function [15:0] pct_to_hz;
        input [15:0] pct;
        input [15:0] fmax;
        reg signed [32:0] prod;
        begin
            prod = $signed(pct) * $signed({1'b0, fmax});
            pct_to_hz = prod[29:14];
        end
    endfunction

    function signed [15:0] clamp16;
        input signed [15:0] v;
        input signed [15:0] lo;
        input signed [15:0] hi;
        begin
            if (v > hi)
                clamp16 = hi;
            else if (v < lo)
                clamp16 = lo;
            else
                clamp16 = v;
        end
    endfunction

    reg [7:0]  ctrl_reg;
    reg [15:0] maxf_reg;
    reg [15:0] lim_hi_reg;
    reg [15:0] lim_lo_reg;
    reg [15:0] su_freq_reg;
    reg [15:0] su_exit_reg;
    reg [15:0] su_dly_reg;
    reg [15:0] sl_dly_reg;
    reg [15:0] sl_freq_reg;
    reg [15:0] wake_lev_reg;
    reg [11:0] byp_reg;
    reg [3:0]  istat_reg;
    reg [3:0]  imask_reg;
    reg [2:0]  state_reg;
    reg [31:0] tick_cnt_reg;
    reg        tick_reg;
    reg [10:0] mfi_meta_reg;
    reg [10:0] mfi_sync_reg;

    reg [2:0]  state_next;
    reg [15:0] freq_next;
    reg [3:0]  evt_next;
    reg [3:0]  istat_next;
    reg [31:0] rdata_next;
    reg        hit_next;

    wire       run_en   = ctrl_reg[`PIDSQ_CTRL_RUN];
    wire       su_en    = ctrl_reg[`PIDSQ_CTRL_SU_EN];
    wire       rev_en   = ctrl_reg[`PIDSQ_CTRL_REV];
    wire [1:0] wake_sel = ctrl_reg[`PIDSQ_CTRL_WMODE +: 2];

    wire signed [15:0] ref_s = reference_pct_i;
    wire signed [15:0] fb_s  = feedback_pct_i;
    wire signed [15:0] pid_s = pid_output_pct_i;
    wire signed [15:0] err_s = ref_s - fb_s;

    // Negative lower limit is only honoured when reverse is allowed
    wire signed [15:0] lim_lo_eff =
        (!rev_en && $signed(lim_lo_reg) < 0) ? 16'sh0000 : $signed(lim_lo_reg);

    wire signed [15:0] pid_clamped =
        clamp16(pid_s, lim_lo_eff, $signed(lim_hi_reg));
    wire signed [15:0] pid_hz_raw = pct_to_hz(pid_clamped, maxf_reg);
    wire signed [15:0] pid_hz =
        (!rev_en && pid_hz_raw < 0) ? 16'sh0000 : pid_hz_raw;
    wire signed [15:0] open_hz = pct_to_hz(ref_s, maxf_reg);

    wire [3:0] byp_term = byp_reg[`PIDSQ_BYP_TERM +: 4];
    wire       byp_term_ok = byp_term < `PIDSQ_N_TERM;
    wire       byp_req =
        (byp_reg[`PIDSQ_BYP_CODE +: 8] == `PIDSQ_FUNC_OPENLOOP) &&
        byp_term_ok && mfi_sync_reg[byp_term];

    wire fb_passed = fb_s > $signed(su_exit_reg);
    wire su_hold   = (state_reg == ST_STARTUP) && !fb_passed;
    wire sl_hold   = (state_reg == ST_PID) &&
                     (pid_hz < $signed(sl_freq_reg));
    wire su_expired;
    wire sl_expired;

    reg wake_hit;
    always @* begin
        case (wake_sel)
            2'h0: wake_hit = fb_s < $signed(wake_lev_reg);
            2'h1: wake_hit = fb_s > $signed(wake_lev_reg);
            2'h2: wake_hit = err_s > $signed(wake_lev_reg);
            default: wake_hit = 1'b0;
        endcase
    end

    // Delay timers; a break in the condition restarts them
    pidsq_hold_timer u_su_timer (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .tick_i    (tick_reg),
        .hold_i    (su_hold),
        .limit_i   (su_dly_reg),
        .expired_o (su_expired)
    );

    pidsq_hold_timer u_sl_timer (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .tick_i    (tick_reg),
        .hold_i    (sl_hold),
        .limit_i   (sl_dly_reg),
        .expired_o (sl_expired)
    );

    always @* begin
        state_next = state_reg;
        evt_next   = 4'h0;
        if (!run_en) begin
            state_next = ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (byp_req)
                        state_next = ST_BYPASS;
                    else if (su_en)
                        state_next = ST_STARTUP;
                    else
                        state_next = ST_PID;
                end
                ST_STARTUP: begin
                    if (su_expired) begin
                        state_next = ST_TRIP;
                        evt_next[`PIDSQ_IRQ_TRIP] = 1'b1;
                    end else if (byp_req) begin
                        state_next = ST_BYPASS;
                        evt_next[`PIDSQ_IRQ_BYP] = 1'b1;
                    end else if (fb_passed) begin
                        state_next = ST_PID;
                    end
                end
                ST_PID: begin
                    if (byp_req) begin
                        state_next = ST_BYPASS;
                        evt_next[`PIDSQ_IRQ_BYP] = 1'b1;
                    end else if (sl_expired) begin
                        state_next = ST_SLEEP;
                        evt_next[`PIDSQ_IRQ_SLEEP] = 1'b1;
                    end
                end
                ST_SLEEP: begin
                    if (byp_req) begin
                        state_next = ST_BYPASS;
                        evt_next[`PIDSQ_IRQ_BYP] = 1'b1;
                    end else if (wake_hit) begin
                        state_next = ST_PID;
                        evt_next[`PIDSQ_IRQ_WAKE] = 1'b1;
                    end
                end
                ST_BYPASS: begin
                    if (!byp_req) begin
                        state_next = ST_PID;
                        evt_next[`PIDSQ_IRQ_BYP] = 1'b1;
                    end
                end
                ST_TRIP: state_next = ST_TRIP;
                default: state_next = ST_IDLE;
            endcase
        end
    end

    // Output follows the state being entered, so it never lags a stop
    always @* begin
        case (state_next)
            ST_STARTUP: freq_next = su_freq_reg;
            ST_PID:     freq_next = pid_hz;
            ST_BYPASS:  freq_next = open_hz;
            default:    freq_next = 16'h0000;
        endcase
    end

    // APB decode
    wire apb_setup = psel_i && !penable_i;
    wire apb_wr    = psel_i && penable_i && pready_o && pwrite_i;
    wire w1c_hit   = apb_wr && paddr_i == `PIDSQ_OFS_ISTAT;

    always @* begin
        hit_next   = 1'b1;
        rdata_next = 32'h0000_0000;
        case (paddr_i)
            `PIDSQ_OFS_CTRL:     rdata_next[7:0]  = ctrl_reg;
            `PIDSQ_OFS_MAXF:     rdata_next[15:0] = maxf_reg;
            `PIDSQ_OFS_LIMIT:    rdata_next = {lim_hi_reg, lim_lo_reg};
            `PIDSQ_OFS_SU_FREQ:  rdata_next[15:0] = su_freq_reg;
            `PIDSQ_OFS_SU_EXIT:  rdata_next[15:0] = su_exit_reg;
            `PIDSQ_OFS_SU_DLY:   rdata_next[15:0] = su_dly_reg;
            `PIDSQ_OFS_SL_DLY:   rdata_next[15:0] = sl_dly_reg;
            `PIDSQ_OFS_SL_FREQ:  rdata_next[15:0] = sl_freq_reg;
            `PIDSQ_OFS_WAKE_LEV: rdata_next[15:0] = wake_lev_reg;
            `PIDSQ_OFS_BYP:      rdata_next[11:0] = byp_reg;
            `PIDSQ_OFS_STAT:     rdata_next[3:0]  = {byp_req, state_reg};
            `PIDSQ_OFS_ISTAT:    rdata_next[3:0]  = istat_reg;
            `PIDSQ_OFS_IMASK:    rdata_next[3:0]  = imask_reg;
            `PIDSQ_OFS_FOUT:     rdata_next[15:0] = freq_cmd_o;
            default:             hit_next = 1'b0;
        endcase
    end

    // New events win over a same-cycle write-one-to-clear
    always @* begin
        istat_next = istat_reg;
        if (w1c_hit)
            istat_next = istat_next & ~pwdata_i[3:0];
        istat_next = istat_next | evt_next;
    end

    // Answer one cycle after setup; data captured at setup
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= apb_setup;
            pslverr_o <= apb_setup && !hit_next;
            if (apb_setup && !pwrite_i)
                prdata_o <= rdata_next;
        end
    end

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_reg     <= `PIDSQ_RST_CTRL;
            maxf_reg     <= `PIDSQ_RST_MAXF;
            lim_hi_reg   <= `PIDSQ_RST_LIM_HI;
            lim_lo_reg   <= `PIDSQ_RST_LIM_LO;
            su_freq_reg  <= `PIDSQ_RST_WORD;
            su_exit_reg  <= `PIDSQ_RST_WORD;
            su_dly_reg   <= `PIDSQ_RST_WORD;
            sl_dly_reg   <= `PIDSQ_RST_WORD;
            sl_freq_reg  <= `PIDSQ_RST_WORD;
            wake_lev_reg <= `PIDSQ_RST_WORD;
            byp_reg      <= `PIDSQ_RST_BYP;
            imask_reg    <= 4'h0;
        end else if (apb_wr) begin
            case (paddr_i)
                `PIDSQ_OFS_CTRL:     ctrl_reg     <= pwdata_i[7:0];
                `PIDSQ_OFS_MAXF:     maxf_reg     <= pwdata_i[15:0];
                `PIDSQ_OFS_LIMIT: begin
                    lim_hi_reg <= pwdata_i[31:16];
                    lim_lo_reg <= pwdata_i[15:0];
                end
                `PIDSQ_OFS_SU_FREQ:  su_freq_reg  <= pwdata_i[15:0];
                `PIDSQ_OFS_SU_EXIT:  su_exit_reg  <= pwdata_i[15:0];
                `PIDSQ_OFS_SU_DLY:   su_dly_reg   <= pwdata_i[15:0];
                `PIDSQ_OFS_SL_DLY:   sl_dly_reg   <= pwdata_i[15:0];
                `PIDSQ_OFS_SL_FREQ:  sl_freq_reg  <= pwdata_i[15:0];
                `PIDSQ_OFS_WAKE_LEV: wake_lev_reg <= pwdata_i[15:0];
                `PIDSQ_OFS_BYP:      byp_reg      <= pwdata_i[11:0];
                `PIDSQ_OFS_IMASK:    imask_reg    <= pwdata_i[3:0];
                default:             imask_reg    <= imask_reg;
            endcase
        end
    end

    // Terminal pins are asynchronous to the system clock
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mfi_meta_reg <= 11'h000;
            mfi_sync_reg <= 11'h000;
        end else begin
            mfi_meta_reg <= multi_function_inputs_i;
            mfi_sync_reg <= mfi_meta_reg;
        end
    end

    // 1 ms tick for the delay timers
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg >= TICK_CYCLES - 1) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            tick_reg     <= 1'b0;
        end
    end

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg       <= ST_IDLE;
            istat_reg       <= 4'h0;
            freq_cmd_o      <= 16'h0000;
            running_o       <= 1'b0;
            startup_trip_o  <= 1'b0;
            sleeping_o      <= 1'b0;
            bypass_active_o <= 1'b0;
            irq_o           <= 1'b0;
        end else begin
            state_reg       <= state_next;
            istat_reg       <= istat_next;
            freq_cmd_o      <= freq_next;
            running_o       <= state_next == ST_STARTUP || state_next == ST_PID ||
                               state_next == ST_BYPASS;
            startup_trip_o  <= state_next == ST_TRIP;
            sleeping_o      <= state_next == ST_SLEEP;
            bypass_active_o <= state_next == ST_BYPASS;
            irq_o           <= |(istat_next & imask_reg);
        end
    end
endmodule

`default_nettype wire
